//--- logic/dgp_top.sv
`timescale 1ns/10ps
`include "dgp_regs.svh"

module dgp_top #(
    parameter bit LARGE_PKG = 1'b1
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // first port pins
    input wire dgp_pkg::dgp_byte_t first_port_pin_i,
    output dgp_pkg::dgp_byte_t first_port_pin_o,
    output dgp_pkg::dgp_byte_t first_port_pin_oe,
    // second port pins and pull-ups
    input wire dgp_pkg::dgp_byte_t second_port_pin_i,
    output dgp_pkg::dgp_byte_t second_port_pin_o,
    output dgp_pkg::dgp_byte_t second_port_pin_oe,
    output dgp_pkg::dgp_byte_t second_port_pullup_en,
    // external memory bus
    input wire logic [3:0] ext_bus_addr_hi,
    input wire dgp_pkg::dgp_byte_t ext_bus_ctrl,
    output logic ext_bus_en,
    // enhanced pwm outputs, order p3c p3b p1c p1b (pins 4 to 7)
    input wire logic pwm_remap_config,
    input wire logic [3:0] pwm_out,
    input wire logic [3:0] pwm_out_en,
    input wire logic [3:0] pwm_shutdown_tri,
    // parallel master port
    input wire logic parallel_port_remap_config,
    input wire dgp_pkg::dgp_byte_t pport_data,
    input wire logic pport_data_oe,
    input wire logic pport_byte_enable,
    input wire logic pport_read_strobe,
    input wire logic pport_write_strobe,
    input wire logic [2:0] pport_ctl_en,
    output logic [2:0] pport_data_in
);
    import dgp_pkg::*;

    dgp_port_if h_if ();
    dgp_port_if j_if ();

    // registers
    dgp_byte_t h_lat_q;
    dgp_byte_t h_dir_q;
    dgp_byte_t j_lat_q;
    dgp_byte_t j_dir_q;
    dgp_byte_t ana_q;
    dgp_byte_t wdt_q;
    dgp_byte_t memctl_q;
    logic pullup_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic ext_en_q;
    dgp_byte_t pu_out_q;
    logic [2:0] pp_in_q;

    // one implementation flag for every port register
    wire logic impl = LARGE_PKG;

    // widen a byte to a bus word, upper bits read as zero
    function automatic logic [31:0] dgp_word(input dgp_byte_t b);
        dgp_word = {24'h000000, b};
    endfunction : dgp_word

    // gate a register value by the package flag
    function automatic dgp_byte_t dgp_gate(input logic en, input dgp_byte_t b);
        dgp_gate = en ? b : 8'h00;
    endfunction : dgp_gate

    // bus decode
    // unmapped offsets read zero and drop writes; the
    // handshake is the same for every address, so a bad
    // offset gets no error response, only silence

    // the shared analog select sits behind the watchdog gate; with the
    // gate closed that address belongs to another block and reads zero
    wire logic shared_open = wdt_q[`DGP_BIT_SHARED_EN];

    wire dgp_sel_e sel_port =
        (address == `DGP_OFF_H_PINS) ? DGP_SEL_H_PINS :
        (address == `DGP_OFF_H_LAT) ? DGP_SEL_H_LAT :
        (address == `DGP_OFF_H_DIR) ? DGP_SEL_H_DIR :
        (address == `DGP_OFF_J_PINS) ? DGP_SEL_J_PINS :
        (address == `DGP_OFF_J_LAT) ? DGP_SEL_J_LAT :
        (address == `DGP_OFF_J_DIR) ? DGP_SEL_J_DIR : DGP_SEL_NONE;

    wire dgp_sel_e sel_misc =
        (address == `DGP_OFF_G_PINS) ? DGP_SEL_G_PINS :
        (address == `DGP_OFF_WDT) ? DGP_SEL_WDT :
        (address == `DGP_OFF_MEMCTL) ? DGP_SEL_MEMCTL :
        (address == `DGP_OFF_ANA_HI && shared_open) ? DGP_SEL_ANA_HI : DGP_SEL_NONE;

    // port registers vanish on the small package
    wire dgp_sel_e sel = (sel_port != DGP_SEL_NONE) ? (impl ? sel_port : DGP_SEL_NONE) : sel_misc;

    // a request is taken once, on the edge where waitrequest is high
    wire logic take = (read | write) & wait_q;
    wire logic wr_en = take & write & byteenable[0];
    wire dgp_byte_t wbyte = writedata[7:0];

    // read data
    // the bus word is built from one byte; nothing above
    // bit 7 is ever driven, and analog-selected pins read
    // low on purpose so a floating analog level never leaks

    // analog pins read as zero on the digital input path
    wire dgp_byte_t h_digital = {ana_q[7:4], 4'hF};
    wire dgp_byte_t h_pins_rd = h_if.pin_sync & h_digital;
    wire dgp_byte_t g_rd = {2'h0, pullup_q & impl, 5'h00};

    // latch reads return what was stored, not the pin level
    wire dgp_byte_t rd_byte =
        (sel == DGP_SEL_H_PINS) ? h_pins_rd :
        (sel == DGP_SEL_H_LAT) ? h_lat_q :
        (sel == DGP_SEL_H_DIR) ? h_dir_q :
        (sel == DGP_SEL_J_PINS) ? j_if.pin_sync :
        (sel == DGP_SEL_J_LAT) ? j_lat_q :
        (sel == DGP_SEL_J_DIR) ? j_dir_q :
        (sel == DGP_SEL_G_PINS) ? g_rd :
        (sel == DGP_SEL_ANA_HI) ? ana_q :
        (sel == DGP_SEL_WDT) ? wdt_q :
        (sel == DGP_SEL_MEMCTL) ? memctl_q : 8'h00;

    // bus handshake: one wait cycle, then a single acknowledge cycle;
    // the write lands on the same edge that drops waitrequest
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q <= ~take;
            if (take && read) begin
                rdata_q <= dgp_word(rd_byte);
            end
        end
    end

    assign readdata = rdata_q;
    assign waitrequest = wait_q;

    // first port registers
    // direction resets to all inputs so no pin drives
    // before software has chosen a level; writes come
    // through either the pin offset or the latch offset

    // the pin address and the latch address both land in the latch
    wire logic h_lat_we = wr_en & (sel == DGP_SEL_H_PINS || sel == DGP_SEL_H_LAT);
    wire logic h_dir_we = wr_en & (sel == DGP_SEL_H_DIR);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            h_lat_q <= `DGP_RST_LAT;
            h_dir_q <= `DGP_RST_DIR;
        end else begin
            if (h_lat_we) begin
                h_lat_q <= wbyte;
            end
            if (h_dir_we) begin
                h_dir_q <= wbyte;
            end
        end
    end

    // second port registers
    // same shape as the first port; the memory bus
    // override never writes back into these, so software
    // finds its own direction again once the bus is off

    wire logic j_lat_we = wr_en & (sel == DGP_SEL_J_PINS || sel == DGP_SEL_J_LAT);
    wire logic j_dir_we = wr_en & (sel == DGP_SEL_J_DIR);

    // every reset leaves the second port as inputs
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            j_lat_q <= `DGP_RST_LAT;
            j_dir_q <= `DGP_RST_DIR;
        end else begin
            if (j_lat_we) begin
                j_lat_q <= wbyte;
            end
            if (j_dir_we) begin
                j_dir_q <= wbyte;
            end
        end
    end

    // control registers
    // watchdog and memory control keep all eight bits
    // but only one of each matters here; the pull-up
    // bit lives in the third port's slot

    // pull-up bit has no latch or direction of its own; only bit 5 is kept
    wire logic pu_we = wr_en & impl & (sel == DGP_SEL_G_PINS);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pullup_q <= `DGP_RST_PULLUP;
            ana_q <= `DGP_RST_ANA;
            wdt_q <= `DGP_RST_WDT;
            memctl_q <= `DGP_RST_MEMCTL;
        end else begin
            if (pu_we) begin
                pullup_q <= wbyte[`DGP_BIT_PULLUP];
            end
            if (wr_en && sel == DGP_SEL_ANA_HI) begin
                ana_q <= wbyte;
            end
            if (wr_en && sel == DGP_SEL_WDT) begin
                wdt_q <= wbyte;
            end
            if (wr_en && sel == DGP_SEL_MEMCTL) begin
                memctl_q <= wbyte;
            end
        end
    end

    // the external bus only exists on the large package
    wire logic ext_on = ~memctl_q[`DGP_BIT_EXT_BUS_DIS] & impl;

    // first port overrides
    // each source raises an enable per pin; the winner
    // is picked below, the latch only when none claims,
    // and direction is bypassed, never rewritten

    // address lines 16 to 19 on pins 0 to 3 beat everything else
    wire dgp_byte_t ext_act = {4'h0, {4{ext_on}}};
    wire dgp_byte_t ext_val = {4'h0, ext_bus_addr_hi};

    // pwm outputs only claim pins when routed here and running
    wire logic [3:0] pw_act4 = {4{~pwm_remap_config}} & pwm_out_en;
    wire dgp_byte_t pw_act = {pw_act4, 4'h0};
    wire dgp_byte_t pw_val = {pwm_out, 4'h0};
    wire dgp_byte_t pw_oe = {~pwm_shutdown_tri, 4'h0};

    // parallel port: data 7,6,3 on pins 2-4; be, rd, wr on pins 5-7
    wire logic pp_on = ~parallel_port_remap_config;
    wire dgp_byte_t pp_req = {pport_ctl_en, {3{pport_data_oe}}, 2'h0};
    wire dgp_byte_t pp_act = pp_on ? pp_req : 8'h00;
    wire dgp_byte_t pp_val = {pport_write_strobe, pport_read_strobe, pport_byte_enable,
                              pport_data[3], pport_data[6], pport_data[7], 2'h0};

    // priority: memory bus, then pwm, then parallel port, then latch
    wire dgp_byte_t pw_win = pw_act & ~ext_act;
    wire dgp_byte_t pp_win = pp_act & ~ext_act & ~pw_act;

    assign h_if.lat = h_lat_q;
    assign h_if.dir = h_dir_q;
    assign h_if.ovr_en = ext_act | pw_act | pp_act;
    assign h_if.ovr_val = (ext_act & ext_val) | (pw_win & pw_val) | (pp_win & pp_val);
    // analog select is absent here on purpose: the output driver keeps working
    assign h_if.ovr_oe = ext_act | (pw_win & pw_oe) | pp_win;

    // second port overrides
    // the memory bus takes all eight pins at once, there
    // is no per-pin choice; the pull-ups drop by themselves
    // because the forced enables count as driving

    // pins 0-7: ale, oe, wr-low, wr-high, ba0, ce, lb, ub from the bus
    assign j_if.lat = j_lat_q;
    assign j_if.dir = j_dir_q;
    assign j_if.ovr_en = {8{ext_on}};
    assign j_if.ovr_val = ext_bus_ctrl;
    assign j_if.ovr_oe = 8'hFF;

    // pad logic
    // both ports share one pad module; only the override
    // wiring differs, and pin levels cross two flops
    // there before any reader sees them

    dgp_port u_h_port (
        .clock(clock),
        .nrst(nrst),
        .ctl(h_if.pad),
        .pin_i(first_port_pin_i),
        .pin_o(first_port_pin_o),
        .pin_oe(first_port_pin_oe)
    );

    dgp_port u_j_port (
        .clock(clock),
        .nrst(nrst),
        .ctl(j_if.pad),
        .pin_i(second_port_pin_i),
        .pin_o(second_port_pin_o),
        .pin_oe(second_port_pin_oe)
    );

    // pull-ups and side outputs
    // registered so every top output comes from a flop,
    // at the cost of one cycle of lag; the parallel port
    // input reuses the synced first port levels

    // pull-ups follow the registered enables, so they drop one cycle
    // after a pin starts driving; harmless since the driver wins anyway
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pu_out_q <= 8'h00;
            ext_en_q <= 1'b0;
            pp_in_q <= 3'h0;
        end else begin
            pu_out_q <= {8{pullup_q & impl}} & ~second_port_pin_oe;
            ext_en_q <= ext_on;
            pp_in_q <= {h_if.pin_sync[2], h_if.pin_sync[3], h_if.pin_sync[4]};
        end
    end

    assign second_port_pullup_en = pu_out_q;
    assign ext_bus_en = ext_en_q;
    assign pport_data_in = pp_in_q;

endmodule : dgp_top

//--- logic/dgp_regs.svh
`ifndef DGP_REGS_SVH
`define DGP_REGS_SVH

// byte offsets on the register bus
`define DGP_OFF_H_PINS 6'h00
`define DGP_OFF_H_LAT 6'h04
`define DGP_OFF_H_DIR 6'h08
`define DGP_OFF_J_PINS 6'h0C
`define DGP_OFF_J_LAT 6'h10
`define DGP_OFF_J_DIR 6'h14
`define DGP_OFF_G_PINS 6'h18
`define DGP_OFF_ANA_HI 6'h1C
`define DGP_OFF_WDT 6'h20
`define DGP_OFF_MEMCTL 6'h24

// field positions
`define DGP_BIT_SHARED_EN 4
`define DGP_BIT_EXT_BUS_DIS 7
`define DGP_BIT_PULLUP 5

// reset values
`define DGP_RST_LAT 8'h00
`define DGP_RST_DIR 8'hFF
`define DGP_RST_ANA 8'h00
`define DGP_RST_WDT 8'h00
`define DGP_RST_MEMCTL 8'h80
`define DGP_RST_PULLUP 1'h0

`endif

//--- logic/dgp_pkg.sv
package dgp_pkg;

    typedef logic [7:0] dgp_byte_t;

    // register selected by the current bus address
    typedef enum logic [3:0] {
        DGP_SEL_NONE,
        DGP_SEL_H_PINS,
        DGP_SEL_H_LAT,
        DGP_SEL_H_DIR,
        DGP_SEL_J_PINS,
        DGP_SEL_J_LAT,
        DGP_SEL_J_DIR,
        DGP_SEL_G_PINS,
        DGP_SEL_ANA_HI,
        DGP_SEL_WDT,
        DGP_SEL_MEMCTL
    } dgp_sel_e;

endpackage : dgp_pkg

//--- logic/dgp_port_if.sv
`timescale 1ns/10ps

// control of one 8-pin port between the register file and the pad logic
interface dgp_port_if;
    dgp_pkg::dgp_byte_t lat;
    dgp_pkg::dgp_byte_t dir;
    dgp_pkg::dgp_byte_t ovr_en;
    dgp_pkg::dgp_byte_t ovr_val;
    dgp_pkg::dgp_byte_t ovr_oe;
    dgp_pkg::dgp_byte_t pin_sync;

    modport ctl (output lat, output dir, output ovr_en, output ovr_val, output ovr_oe, input pin_sync);
    modport pad (input lat, input dir, input ovr_en, input ovr_val, input ovr_oe, output pin_sync);
endinterface : dgp_port_if

//--- logic/dgp_port.sv
`timescale 1ns/10ps

module dgp_port (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // register side
    dgp_port_if.pad ctl,
    // pins
    input wire dgp_pkg::dgp_byte_t pin_i,
    output dgp_pkg::dgp_byte_t pin_o,
    output dgp_pkg::dgp_byte_t pin_oe
);
    import dgp_pkg::*;

    dgp_byte_t meta_q;
    dgp_byte_t sync_q;

    // a peripheral override picks value and enable; it never touches the
    // stored direction, so software read-modify-write stays safe
    wire dgp_byte_t out_d = (ctl.ovr_en & ctl.ovr_val) | (~ctl.ovr_en & ctl.lat);
    wire dgp_byte_t oe_d = (ctl.ovr_en & ctl.ovr_oe) | (~ctl.ovr_en & ~ctl.dir);

    // two stages on the pin level; stands in for the schmitt input stage
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    // pad drivers, registered so the pins never see decode glitches
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pin_o <= 8'h00;
            pin_oe <= 8'h00;
        end else begin
            pin_o <= out_d;
            pin_oe <= oe_d;
        end
    end

    assign ctl.pin_sync = sync_q;

endmodule : dgp_port

//--- dv/dgp_top_asserts.sv
`timescale 1ns/10ps

module dgp_top_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // register bus
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // pins
    input wire dgp_pkg::dgp_byte_t first_port_pin_o,
    input wire dgp_pkg::dgp_byte_t first_port_pin_oe,
    input wire dgp_pkg::dgp_byte_t second_port_pin_o,
    input wire dgp_pkg::dgp_byte_t second_port_pin_oe,
    input wire dgp_pkg::dgp_byte_t second_port_pullup_en,
    // overriding functions
    input wire logic [3:0] ext_bus_addr_hi,
    input wire dgp_pkg::dgp_byte_t ext_bus_ctrl,
    input wire logic ext_bus_en,
    input wire logic pwm_remap_config,
    input wire logic [3:0] pwm_out,
    input wire logic [3:0] pwm_out_en,
    input wire logic [3:0] pwm_shutdown_tri
);
    import dgp_pkg::*;
    // one clock domain, so one clocking and one reset for all
    default clocking @(posedge clock);
    endclocking
    default disable iff (!nrst);

    // handshake: one cycle to answer, low for one cycle only
    a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
    a_wait_single: assert property (!waitrequest |=> waitrequest) else $error("wait low too long");
    a_read_upper: assert property (!waitrequest |-> readdata[31:8] == 24'h000000) else $error("upper data set");
    // memory bus takes pins, one pad register behind its inputs
    a_addr_override: assert property (ext_bus_en && $past(ext_bus_en) |-> first_port_pin_oe[3:0] == 4'hF
        && first_port_pin_o[3:0] == $past(ext_bus_addr_hi)) else $error("address pins wrong");
    a_ctrl_override: assert property (ext_bus_en && $past(ext_bus_en) |-> second_port_pin_oe == 8'hFF
        && second_port_pin_o == $past(ext_bus_ctrl)) else $error("control pins wrong");
    // pull-up follows the driver one cycle late, never on where the pin drove the cycle before
    a_pullup_output: assert property ((second_port_pullup_en & $past(second_port_pin_oe)) == 8'h00)
        else $error("pull-up on a driven pin");
    a_reset_inputs: assert property ($rose(nrst) |-> second_port_pin_oe == 8'h00
        && second_port_pullup_en == 8'h00) else $error("second port not idle after reset");
    a_pwm_drive: assert property ($past(nrst && !pwm_remap_config
        && pwm_out_en == 4'hF && pwm_shutdown_tri == 4'h0)
        |-> first_port_pin_oe[7:4] == 4'hF && first_port_pin_o[7:4] == $past(pwm_out))
        else $error("pwm not on pins");
    a_pwm_tristate: assert property ($past(nrst && !pwm_remap_config)
        |-> (first_port_pin_oe[7:4] & $past(pwm_out_en & pwm_shutdown_tri)) == 4'h0)
        else $error("pwm shutdown still drives");

    c_write_done: cover property (write && !waitrequest);
    c_ext_bus: cover property (ext_bus_en && $past(ext_bus_en));
    c_pwm_off: cover property (!pwm_remap_config && pwm_shutdown_tri != 4'h0);
endmodule : dgp_top_asserts

//--- dv/dgp_pin_model.sv
`timescale 1ns/10ps

module dgp_pin_model (
    // clock
    input wire logic clock,
    // device side of the pads
    input wire dgp_pkg::dgp_byte_t pin_o,
    input wire dgp_pkg::dgp_byte_t pin_oe,
    input wire dgp_pkg::dgp_byte_t pullup_en,
    // outside drivers
    input wire dgp_pkg::dgp_byte_t ext_val,
    input wire dgp_pkg::dgp_byte_t ext_drive,
    // resolved level
    output dgp_pkg::dgp_byte_t pin_i
);
    import dgp_pkg::*;
    dgp_byte_t float_q = 8'h5A;

    // an undriven, unpulled wire wanders, so a stale value never reads as valid
    always @(posedge clock) begin
        float_q <= ~float_q;
    end

    // device driver first, then outside driver, then weak pull-up
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_drive & ext_val)
        | (~pin_oe & ~ext_drive & (pullup_en | float_q));
endmodule : dgp_pin_model

//--- dv/dual_gpio_port_override_test.sv
`timescale 1ns/10ps
`include "dgp_regs.svh"

module dual_gpio_port_override_test;
    import dgp_pkg::*;
    logic clock = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0, pwm_remap_config = 1'b1;
    logic parallel_port_remap_config = 1'b1, pport_data_oe = 1'b0, pport_byte_enable = 1'b0;
    logic pport_read_strobe = 1'b0, pport_write_strobe = 1'b0, ext_bus_en, waitrequest;
    logic [5:0] address = 6'h00;
    logic [31:0] writedata = 32'h0, readdata, seed = 32'h6E273D3F;
    logic [3:0] byteenable = 4'hF, ext_bus_addr_hi = 4'h0, pwm_out = 4'h0, pwm_out_en = 4'h0, pwm_shutdown_tri = 4'h0;
    logic [2:0] pport_ctl_en = 3'h0;
    dgp_byte_t ext_bus_ctrl = 8'h00, pport_data = 8'h00, h_val = 8'h00, h_drv = 8'h00, v;
    dgp_byte_t h_pin_i, h_pin_o, h_pin_oe, j_pin_i, j_pin_o, j_pin_oe, j_pull;
    dgp_byte_t exp_q[$];
    dgp_byte_t rd_exp;
    logic [31:0] rd_small;
    logic [2:0] pp_in;
    logic ext_small;
    int compares = 0, miscompares = 0;
    logic [13:0] rst_tab [9] = '{{`DGP_OFF_H_LAT, 8'h00}, {`DGP_OFF_H_DIR, 8'hFF}, {`DGP_OFF_J_LAT, 8'h00},
        {`DGP_OFF_J_DIR, 8'hFF}, {`DGP_OFF_G_PINS, 8'h00}, {`DGP_OFF_ANA_HI, 8'h00}, {`DGP_OFF_WDT, 8'h00},
        {`DGP_OFF_MEMCTL, 8'h80}, {6'h28, 8'h00}};

    // 10 MHz clock
    always #50 clock = ~clock;

    dgp_top i_dgp_top (.clock, .nrst, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
        .first_port_pin_i(h_pin_i), .first_port_pin_o(h_pin_o), .first_port_pin_oe(h_pin_oe),
        .second_port_pin_i(j_pin_i), .second_port_pin_o(j_pin_o), .second_port_pin_oe(j_pin_oe),
        .second_port_pullup_en(j_pull), .ext_bus_addr_hi, .ext_bus_ctrl, .ext_bus_en, .pwm_remap_config,
        .pwm_out, .pwm_out_en, .pwm_shutdown_tri, .parallel_port_remap_config, .pport_data, .pport_data_oe,
        .pport_byte_enable, .pport_read_strobe, .pport_write_strobe, .pport_ctl_en, .pport_data_in(pp_in));
    // small package copy on the same bus: port registers, pull-up bit and external bus are gone
    dgp_top #(.LARGE_PKG(1'b0)) i_dgp_top_small (.clock, .nrst, .address, .read, .write, .writedata,
        .byteenable, .readdata(rd_small), .waitrequest(), .first_port_pin_i(h_pin_i), .first_port_pin_o(),
        .first_port_pin_oe(), .second_port_pin_i(j_pin_i), .second_port_pin_o(), .second_port_pin_oe(),
        .second_port_pullup_en(), .ext_bus_addr_hi, .ext_bus_ctrl, .ext_bus_en(ext_small), .pwm_remap_config,
        .pwm_out, .pwm_out_en, .pwm_shutdown_tri, .parallel_port_remap_config, .pport_data, .pport_data_oe,
        .pport_byte_enable, .pport_read_strobe, .pport_write_strobe, .pport_ctl_en, .pport_data_in());
    // offsets that vanish on the small package
    wire logic small_gone = (address <= `DGP_OFF_J_DIR) || (address == `DGP_OFF_G_PINS);
    dgp_pin_model h_pins (.clock, .pin_o(h_pin_o), .pin_oe(h_pin_oe), .pullup_en(8'h00), .ext_val(h_val),
        .ext_drive(h_drv), .pin_i(h_pin_i));
    dgp_pin_model j_pins (.clock, .pin_o(j_pin_o), .pin_oe(j_pin_oe), .pullup_en(j_pull), .ext_val(8'h00),
        .ext_drive(8'h00), .pin_i(j_pin_i));

    task automatic wrap_up;
        if (miscompares == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // request held until waitrequest is sampled low, then released
    task automatic bus_go(input logic [5:0] a, input logic rd, input dgp_byte_t d);
        int n;
        @(posedge clock);
        address <= a;
        writedata <= {24'h000000, d};
        read <= rd;
        write <= !rd;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            miscompares++;
            wrap_up();
        end
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus_go

    task automatic bus_rd(input logic [5:0] a, input dgp_byte_t e);
        exp_q.push_back(e);
        bus_go(a, 1'b1, 8'h00);
    endtask : bus_rd

    // let pad and sync registers settle; outputs are read at an edge where they
    // have stood still for cycles, and new inputs follow on that same edge
    task automatic settle;
        repeat (5) @(posedge clock);
    endtask : settle

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // read data are taken at the edge where waitrequest is low
    always @(posedge clock) begin
        if (read && waitrequest === 1'b0 && exp_q.size() > 0) begin
            rd_exp = exp_q.pop_front();
            check(readdata, {24'h000000, rd_exp});
            check(rd_small, small_gone ? 32'h00000000 : {24'h000000, rd_exp});
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        foreach (rst_tab[i]) bus_rd(rst_tab[i][13:8], rst_tab[i][7:0]);
        // pin register write lands in the latch; analog pins still drive
        bus_wr_rd: begin
            bus_go(`DGP_OFF_H_PINS, 1'b0, 8'hA5);
            bus_rd(`DGP_OFF_H_LAT, 8'hA5);
            bus_go(`DGP_OFF_H_DIR, 1'b0, 8'h00);
            settle();
            check({h_pin_oe, h_pin_o}, 16'hFFA5);
            byteenable <= 4'h0;
            bus_go(`DGP_OFF_H_LAT, 1'b0, 8'h11);
            byteenable <= 4'hF;
            bus_rd(`DGP_OFF_H_LAT, 8'hA5);
        end
        // inputs: analog pins read low until made digital behind the watchdog gate
        bus_go(`DGP_OFF_H_DIR, 1'b0, 8'hFF);
        h_val <= 8'h2C;
        h_drv <= 8'hFF;
        bus_go(`DGP_OFF_ANA_HI, 1'b0, 8'hF0);
        settle();
        bus_rd(`DGP_OFF_H_PINS, 8'h0C);
        check(pp_in, 3'h6);
        bus_go(`DGP_OFF_WDT, 1'b0, 8'h10);
        bus_rd(`DGP_OFF_ANA_HI, 8'h00);
        bus_go(`DGP_OFF_ANA_HI, 1'b0, 8'hF0);
        bus_rd(`DGP_OFF_H_PINS, 8'h2C);
        bus_go(`DGP_OFF_WDT, 1'b0, 8'h00);
        bus_rd(`DGP_OFF_ANA_HI, 8'h00);
        // pull-ups only on input pins of the second port
        bus_go(`DGP_OFF_G_PINS, 1'b0, 8'h20);
        bus_rd(`DGP_OFF_G_PINS, 8'h20);
        bus_go(`DGP_OFF_J_DIR, 1'b0, 8'h0F);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr_next(seed);
            v = seed[7:0];
            bus_go(`DGP_OFF_J_LAT, 1'b0, v);
            settle();
            check({j_pull, j_pin_oe, j_pin_o[7:4]}, {8'h0F, 8'hF0, v[7:4]});
            bus_rd(`DGP_OFF_J_PINS, {v[7:4], 4'hF});
        end
        bus_go(`DGP_OFF_G_PINS, 1'b0, 8'h00);
        settle();
        check(j_pull, 8'h00);
        // memory bus overrides both ports without touching direction
        seed = lfsr_next(seed);
        ext_bus_addr_hi <= seed[3:0];
        ext_bus_ctrl <= seed[15:8];
        bus_go(`DGP_OFF_MEMCTL, 1'b0, 8'h00);
        settle();
        check({ext_bus_en, j_pin_oe, j_pin_o, h_pin_oe[3:0], h_pin_o[3:0]}, {1'b1, 8'hFF, seed[15:8], 4'hF, seed[3:0]});
        check(ext_small, 1'b0);
        bus_rd(`DGP_OFF_J_DIR, 8'h0F);
        bus_rd(`DGP_OFF_H_DIR, 8'hFF);
        bus_go(`DGP_OFF_MEMCTL, 1'b0, 8'h80);
        // parallel port, then pwm over it, then shutdown, then both remapped away
        bus_go(`DGP_OFF_H_DIR, 1'b0, 8'h00);
        bus_go(`DGP_OFF_H_LAT, 1'b0, 8'h00);
        {parallel_port_remap_config, pwm_remap_config, pport_data_oe, pport_ctl_en} <= 6'b001111;
        {pport_data, pport_byte_enable, pport_read_strobe, pport_write_strobe} <= {8'h88, 3'b101};
        settle();
        check(h_pin_o[7:2], 6'b101101);
        pwm_out_en <= 4'hF;
        pwm_out <= 4'h6;
        settle();
        check(h_pin_o[7:4], 4'h6);
        pwm_shutdown_tri <= 4'hF;
        settle();
        check(h_pin_oe[7:4], 4'h0);
        pwm_remap_config <= 1'b1;
        settle();
        check({h_pin_oe[7:4], h_pin_o[7:4]}, 8'hFB);
        parallel_port_remap_config <= 1'b1;
        settle();
        check(h_pin_o[7:2], 6'b000000);
        // reset in mid-run restores inputs and drops pull-ups
        bus_go(`DGP_OFF_G_PINS, 1'b0, 8'h20);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        settle();
        check({j_pin_oe, j_pull}, 16'h0000);
        bus_rd(`DGP_OFF_J_DIR, 8'hFF);
        bus_rd(`DGP_OFF_G_PINS, 8'h00);
        wrap_up();
    end
endmodule : dual_gpio_port_override_test

bind dgp_top dgp_top_asserts i_dgp_top_asserts (.clock, .nrst, .read, .write, .readdata, .waitrequest,
    .first_port_pin_o, .first_port_pin_oe, .second_port_pin_o, .second_port_pin_oe, .second_port_pullup_en,
    .ext_bus_addr_hi, .ext_bus_ctrl, .ext_bus_en, .pwm_remap_config, .pwm_out, .pwm_out_en, .pwm_shutdown_tri);
